/* File: low_power_mode_sequencer.sv */
// Purpose: sequences run, sleep, stop and standby power states of the core
// Assumes: rst is the power-on reset; sysReset is the reset that this block issues
// Notes: outputs are registered; ce low freezes every flip-flop
//
// Functional notes
// - any reset completes with the regulator in normal full-power mode
// - stop runs the regulator in low power if software selected it, else normal
// - standby switches the regulator off, output high impedance
// - exactly three low-power states: sleep, stop, standby, increasing depth
// - sleep gates only the processor clock, peripheral clocks keep running
// - sleep ends on any interrupt or wake event, without a reset
// - stop puts flash in low power and turns off PLL and fast oscillators
// - stop ends on an event line, reset pin or watchdog reset
// - standby powers only the wake circuit, flash and logic powered down
// - standby wake issues a system reset and sets the standby flag together
// - the standby flag clears only on power-on reset or by software writing the clear bit
// - standby keeps backup registers and optionally retained SRAM
// - standby ends on event line, reset pin, watchdog or wake pin rising edge
// - after any wake the internal oscillator is selected as system clock
// - after reset the core runs from the internal oscillator, enabled by default
//
// Implementation choices: strobed register access and the address map.

module low_power_mode_sequencer (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire lp_seq_pkg::regReq_t regReq,
	output logic [31:0] rdData,
	input wire logic enterReq,
	input wire logic [1:0] modeReq,
	input wire logic irqPending,
	input wire lp_seq_pkg::wakeLines_t wakeLines,
	input wire logic wakeUpPin,
	input wire logic externalResetPin_n,
	input wire logic watchdogReset,
	output lp_seq_pkg::powerCtrl_t pwr,
	output logic sysReset,
	output logic irq
);
	import lp_seq_pkg::*;

	seqState_t state;
	seqState_t next_state;
	powerCtrl_t next_pwr;
	logic [3:0] rstCount;
	logic [CTRL_W-1:0] ctrlReg;
	logic standbyFlag;
	logic [IRQ_W-1:0] irqStatus;
	logic [IRQ_W-1:0] irqMask;
	logic [IRQ_W-1:0] next_irqStatus;
	logic [IRQ_W-1:0] next_irqMask;
	logic [SYN_W-1:0] asyncIn;
	logic [SYN_W-1:0] level;
	logic [SYN_W-1:0] rise;
	logic anyEvent;
	logic standbyEvent;
	logic wakePinRise;
	logic resetCause;
	logic wakeSleep;
	logic wakeStop;
	logic wakeStandby;
	logic wakeAny;
	logic wrCtrl;
	logic clearWrite;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	assign asyncIn = {watchdogReset, externalResetPin_n, wakeUpPin, wakeLines};

	// three stages per pin; the level moves only when stages two and three agree,
	// which filters a metastable first stage and single-cycle glitches
	for (genvar i = 0; i < SYN_W; i++) begin : gSync
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
		logic lvlPrev;
		always_ff @(posedge clk) begin
			if (rst) begin
				s1 <= SYN_RESET[i];
				s2 <= SYN_RESET[i];
				s3 <= SYN_RESET[i];
				lvl <= SYN_RESET[i];
				lvlPrev <= SYN_RESET[i];
			end else if (ce) begin
				s1 <= asyncIn[i];
				s2 <= s1;
				s3 <= s2;
				if (s2 == s3) begin
					lvl <= s3;
				end
				lvlPrev <= lvl;
			end
		end
		assign level[i] = lvl;
		assign rise[i] = lvl & ~lvlPrev;
	end

	// ------------------------------------------------------------
	// wake and reset sources
	// ------------------------------------------------------------
	assign anyEvent = |rise[SYN_EVT_MSB:0];
	assign standbyEvent = |(rise[SYN_EVT_MSB:0] & STANDBY_EVT_MASK);
	assign wakePinRise = rise[SYN_WAKE_PIN];
	// reset pin is a level: while held low the block stays in its reset state
	assign resetCause = ~level[SYN_EXT_RST] | level[SYN_WDOG];
	assign wakeAny = wakeSleep | wakeStop | wakeStandby;

	// ------------------------------------------------------------
	// state sequencing
	// ------------------------------------------------------------
	// reset sources outrank everything; entry only from run on a request
	always_comb begin
		next_state = state;
		wakeSleep = 1'b0;
		wakeStop = 1'b0;
		wakeStandby = 1'b0;
		case (state)
			ST_RUN: begin
				if (resetCause) begin
					next_state = ST_WAKERST;
				end else if (enterReq) begin
					// unknown mode codes are ignored: only three states exist
					if (modeReq == MODE_SLEEP) begin
						next_state = ST_SLEEP;
					end else if (modeReq == MODE_STOP) begin
						next_state = ST_STOP;
					end else if (modeReq == MODE_STANDBY) begin
						next_state = ST_STANDBY;
					end
				end
			end
			ST_SLEEP: begin
				if (resetCause) begin
					next_state = ST_WAKERST;
				end else if (irqPending || anyEvent) begin
					next_state = ST_RUN;
					wakeSleep = 1'b1;
				end
			end
			ST_STOP: begin
				if (resetCause) begin
					next_state = ST_WAKERST;
				end else if (anyEvent) begin
					next_state = ST_RUN;
					wakeStop = 1'b1;
				end
			end
			ST_STANDBY: begin
				// core logic is unpowered, so every exit goes through reset
				if (resetCause || standbyEvent || wakePinRise) begin
					next_state = ST_WAKERST;
					wakeStandby = 1'b1;
				end
			end
			ST_WAKERST: begin
				if (rstCount == 4'h0 && !resetCause) begin
					next_state = ST_RUN;
				end
			end
			default: begin
				next_state = ST_RUN;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= ST_RUN;
		end else if (ce) begin
			state <= next_state;
		end
	end

	// reset pulse length; reloads while a reset source is still active
	always_ff @(posedge clk) begin
		if (rst) begin
			rstCount <= 4'h0;
		end else if (ce) begin
			if (next_state == ST_WAKERST && (state != ST_WAKERST || resetCause)) begin
				rstCount <= WAKE_RST_LOAD;
			end else if (rstCount != 4'h0) begin
				rstCount <= rstCount - 4'h1;
			end
		end
	end

	// system reset follows the reset state, registered with it
	always_ff @(posedge clk) begin
		if (rst) begin
			sysReset <= 1'b0;
		end else if (ce) begin
			sysReset <= (next_state == ST_WAKERST);
		end
	end

	// ------------------------------------------------------------
	// power and clock controls
	// ------------------------------------------------------------
	// decoded from the next state so the outputs change together with the state
	always_comb begin
		next_pwr = PWR_RUN;
		next_pwr.sysClkIntOsc = ~ctrlReg[CTRL_ALT_CLK_BIT] | wakeAny
			| (next_state == ST_WAKERST);
		case (next_state)
			ST_SLEEP: begin
				next_pwr.cpuClkEn = 1'b0;
			end
			ST_STOP: begin
				next_pwr.regMode = ctrlReg[CTRL_STOP_LP_BIT] ? REG_LOW_POWER : REG_ON;
				next_pwr.cpuClkEn = 1'b0;
				next_pwr.periphClkEn = 1'b0;
				next_pwr.flashLowPower = 1'b1;
				next_pwr.pllAllow = 1'b0;
				next_pwr.intOscAllow = 1'b0;
				next_pwr.extOscAllow = 1'b0;
			end
			ST_STANDBY: begin
				next_pwr.regMode = REG_OFF;
				next_pwr.cpuClkEn = 1'b0;
				next_pwr.periphClkEn = 1'b0;
				next_pwr.flashPowerOff = 1'b1;
				next_pwr.pllAllow = 1'b0;
				next_pwr.intOscAllow = 1'b0;
				next_pwr.extOscAllow = 1'b0;
				next_pwr.wakeCircuitOnly = 1'b1;
				next_pwr.sramRetain = ctrlReg[CTRL_SRAM_RET_BIT];
			end
			default: begin
				next_pwr.regMode = REG_ON;
			end
		endcase
	end

	// power control register
	always_ff @(posedge clk) begin
		if (rst) begin
			pwr <= PWR_RUN;
		end else if (ce) begin
			pwr <= next_pwr;
		end
	end

	// ------------------------------------------------------------
	// register port
	// ------------------------------------------------------------
	assign wrCtrl = regReq.wrEn && (regReq.addr == OFF_CTRL);
	assign clearWrite = wrCtrl && regReq.wrData[CTRL_CLEAR_FLAG_BIT];

	// control bits belong to the core domain and fall back on the wake reset
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrlReg <= CTRL_RESET;
		end else if (ce) begin
			if (next_state == ST_WAKERST) begin
				ctrlReg <= CTRL_RESET;
			end else begin
				if (wrCtrl) begin
					ctrlReg <= regReq.wrData[CTRL_W-1:0] & CTRL_STORE_MASK;
				end
				if (wakeAny) begin
					ctrlReg[CTRL_ALT_CLK_BIT] <= 1'b0;
				end
			end
		end
	end

	// flag lives in the always-powered domain: the wake reset leaves it, only power-on reset or the clear bit clears it
	always_ff @(posedge clk) begin
		if (rst) begin
			standbyFlag <= 1'b0;
		end else if (ce) begin
			if (wakeStandby) begin
				standbyFlag <= 1'b1;
			end else if (clearWrite) begin
				standbyFlag <= 1'b0;
			end
		end
	end

	// sticky events, a read clears them but a new event in that cycle survives
	always_comb begin
		next_irqStatus = irqStatus;
		if (regReq.rdEn && regReq.addr == OFF_IRQ_STATUS) begin
			next_irqStatus = IRQ_RESET;
		end
		next_irqStatus[IRQ_SLEEP_BIT] = next_irqStatus[IRQ_SLEEP_BIT] | wakeSleep;
		next_irqStatus[IRQ_STOP_BIT] = next_irqStatus[IRQ_STOP_BIT] | wakeStop;
		next_irqStatus[IRQ_STANDBY_BIT] = next_irqStatus[IRQ_STANDBY_BIT] | wakeStandby;
		next_irqMask = irqMask;
		if (regReq.wrEn && regReq.addr == OFF_IRQ_MASK) begin
			next_irqMask = regReq.wrData[IRQ_W-1:0];
		end
	end

	// interrupt registers survive the wake reset so the standby event is seen
	always_ff @(posedge clk) begin
		if (rst) begin
			irqStatus <= IRQ_RESET;
			irqMask <= IRQ_RESET;
			irq <= 1'b0;
		end else if (ce) begin
			irqStatus <= next_irqStatus;
			irqMask <= next_irqMask;
			irq <= |(next_irqStatus & next_irqMask);
		end
	end

	// read data stands only in the cycle after the read strobe
	always_ff @(posedge clk) begin
		if (rst) begin
			rdData <= 32'h00000000;
		end else if (ce) begin
			if (!regReq.rdEn) begin
				rdData <= 32'h00000000;
			end else if (regReq.addr == OFF_CTRL) begin
				rdData <= 32'(ctrlReg);
			end else if (regReq.addr == OFF_STATUS) begin
				rdData <= 32'({state, 7'h00, standbyFlag});
			end else if (regReq.addr == OFF_IRQ_STATUS) begin
				rdData <= 32'(irqStatus);
			end else if (regReq.addr == OFF_IRQ_MASK) begin
				rdData <= 32'(irqMask);
			end else begin
				rdData <= 32'h00000000;
			end
		end
	end

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst || !ce);

	property p_reg_on_awake;
		(state == ST_RUN || state == ST_SLEEP || state == ST_WAKERST) |-> pwr.regMode == REG_ON;
	endproperty
	a_reg_on_awake: assert property (p_reg_on_awake) else $error("regulator not on");

	property p_stop_regulator;
		(state == ST_STOP && $past(state) == ST_STOP)
			|-> pwr.regMode == ($past(ctrlReg[CTRL_STOP_LP_BIT]) ? REG_LOW_POWER : REG_ON);
	endproperty
	a_stop_regulator: assert property (p_stop_regulator) else $error("stop regulator mode");

	property p_standby_off;
		state == ST_STANDBY |-> pwr.regMode == REG_OFF && pwr.wakeCircuitOnly && pwr.flashPowerOff;
	endproperty
	a_standby_off: assert property (p_standby_off) else $error("standby power wrong");

	property p_bad_mode;
		state == ST_RUN && enterReq && modeReq == 2'h3 && !resetCause |=> state == ST_RUN;
	endproperty
	a_bad_mode: assert property (p_bad_mode) else $error("unknown mode entered");

	property p_sleep_clocks;
		state == ST_SLEEP |-> !pwr.cpuClkEn && pwr.periphClkEn && pwr.intOscAllow;
	endproperty
	a_sleep_clocks: assert property (p_sleep_clocks) else $error("sleep clocks wrong");

	property p_sleep_exit;
		state == ST_SLEEP && irqPending && !resetCause |=> state == ST_RUN && !sysReset;
	endproperty
	a_sleep_exit: assert property (p_sleep_exit) else $error("sleep did not exit");

	property p_stop_osc;
		state == ST_STOP |-> pwr.flashLowPower && !pwr.pllAllow && !pwr.extOscAllow
			&& !pwr.intOscAllow;
	endproperty
	a_stop_osc: assert property (p_stop_osc) else $error("stop oscillators on");

	property p_stop_exit;
		state == ST_STOP && anyEvent && !resetCause |=> state == ST_RUN ##1 pwr.cpuClkEn;
	endproperty
	a_stop_exit: assert property (p_stop_exit) else $error("stop did not exit");

	property p_standby_wake;
		state == ST_STANDBY && wakePinRise |=> sysReset && standbyFlag
			##WAKE_RST_CYCLES !sysReset;
	endproperty
	a_standby_wake: assert property (p_standby_wake) else $error("standby wake wrong");

	property p_flag_clear;
		$fell(standbyFlag) |-> $past(clearWrite);
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag lost");

	property p_wake_int_osc;
		state == ST_RUN && $past(state) != ST_RUN |-> pwr.sysClkIntOsc && pwr.intOscAllow;
	endproperty
	a_wake_int_osc: assert property (p_wake_int_osc) else $error("wake clock wrong");

	property p_no_unrequested;
		state == ST_RUN && !enterReq |=> state == ST_RUN || state == ST_WAKERST;
	endproperty
	a_no_unrequested: assert property (p_no_unrequested) else $error("entry w/o request");

	c_sleep_wake: cover property (state == ST_SLEEP ##1 state == ST_RUN);
	c_stop_wake: cover property (state == ST_STOP ##1 state == ST_RUN);
	c_standby_wake: cover property (state == ST_STANDBY ##1 state == ST_WAKERST ##[1:20]
		state == ST_RUN);
	c_irq: cover property ($rose(irq));

endmodule

/* File: lp_seq_pkg.sv */
// Purpose: shared constants and types for the low-power mode sequencer
// Assumes: one 100 MHz clock, synchronous active-high reset
// Notes: register offsets are byte addresses on the plain register port

package lp_seq_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int WAKE_RST_NS = 100;
	// least time, so round up to whole cycles
	localparam int WAKE_RST_CYCLES = (WAKE_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] WAKE_RST_LOAD = 4'(WAKE_RST_CYCLES - 1);

	// ------------------------------------------------------------
	// register map and fields
	// ------------------------------------------------------------
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h08;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h0C;
	localparam int CTRL_W = 4;
	localparam int CTRL_STOP_LP_BIT = 0;
	localparam int CTRL_ALT_CLK_BIT = 1;
	localparam int CTRL_CLEAR_FLAG_BIT = 2;
	localparam int CTRL_SRAM_RET_BIT = 3;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
	localparam logic [CTRL_W-1:0] CTRL_STORE_MASK = 4'hB;
	localparam int STATUS_STATE_LSB = 8;
	localparam int IRQ_W = 3;
	localparam int IRQ_SLEEP_BIT = 0;
	localparam int IRQ_STOP_BIT = 1;
	localparam int IRQ_STANDBY_BIT = 2;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

	// ------------------------------------------------------------
	// pin synchroniser layout
	// ------------------------------------------------------------
	localparam int SYN_W = 23;
	localparam int SYN_EVT_MSB = 19;
	localparam int SYN_WAKE_PIN = 20;
	localparam int SYN_EXT_RST = 21;
	localparam int SYN_WDOG = 22;
	localparam logic [SYN_W-1:0] SYN_RESET = 23'h200000;
	// the voltage detector line (bit 3) cannot wake from standby
	localparam logic [SYN_EVT_MSB:0] STANDBY_EVT_MASK = 20'hFFFF7;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [4:0] {
		ST_RUN = 5'h01,
		ST_SLEEP = 5'h02,
		ST_STOP = 5'h04,
		ST_STANDBY = 5'h08,
		ST_WAKERST = 5'h10
	} seqState_t;

	typedef enum logic [1:0] {
		MODE_SLEEP = 2'h0,
		MODE_STOP = 2'h1,
		MODE_STANDBY = 2'h2
	} lpMode_t;

	typedef enum logic [1:0] {
		REG_ON = 2'h0,
		REG_LOW_POWER = 2'h1,
		REG_OFF = 2'h2
	} regMode_t;

	typedef struct packed {
		regMode_t regMode;
		logic cpuClkEn;
		logic periphClkEn;
		logic flashLowPower;
		logic flashPowerOff;
		logic pllAllow;
		logic intOscAllow;
		logic extOscAllow;
		logic wakeCircuitOnly;
		logic sramRetain;
		logic sysClkIntOsc;
	} powerCtrl_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wrData;
		logic wrEn;
		logic rdEn;
	} regReq_t;

	typedef struct packed {
		logic [15:0] lines;
		logic voltDetect;
		logic rtcAlarm;
		logic netWake;
		logic usbWake;
	} wakeLines_t;

	localparam powerCtrl_t PWR_RUN = '{REG_ON, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1,
		1'b0, 1'b0, 1'b1};

endpackage

/* File: core_wake_model.sv */
// Purpose: stand-in for the processor core and the wake sources around the sequencer
// Assumes: one clock; the bench calls the tasks, all changes land just after a rising edge
// Notes: wake inputs are held 8 cycles so they outlast the 3-flop synchronisers
module core_wake_model (
	input wire logic clk,
	output logic enterReq,
	output logic [1:0] modeReq,
	output lp_seq_pkg::wakeLines_t wakeLines,
	output logic wakeUpPin,
	output logic watchdogReset,
	output logic externalResetPin_n
);
	timeunit 1ns;
	timeprecision 100ps;
	import lp_seq_pkg::*;

	// one bit per source: 0..19 event lines, 20 wake pin, 21 watchdog, 22 reset pin
	logic [22:0] act;

	// released lines fall back to their pulled idle level
	assign wakeLines = act[19:0];
	assign wakeUpPin = act[20];
	assign watchdogReset = act[21];
	assign externalResetPin_n = ~act[22];

	initial begin
		act = '0;
		enterReq = 1'b0;
		modeReq = 2'h3;
	end

	// entry only ever follows an explicit request carrying a mode
	task automatic request(input logic [1:0] mode);
		@(posedge clk);
		enterReq <= 1'b1;
		modeReq <= mode;
		@(posedge clk);
		enterReq <= 1'b0;
		modeReq <= ~mode;
	endtask

	// a rising edge, held long enough to be seen, then released
	task automatic pulse(input int idx);
		@(posedge clk);
		act[idx] <= 1'b1;
		repeat (8) @(posedge clk);
		act[idx] <= 1'b0;
	endtask
endmodule

/* File: tb.sv */
// Purpose: self-checking bench for the low-power mode sequencer
// Assumes: 100 MHz clock, synchronous reset held 12 cycles, ce high except one freeze test
// Notes: random choices come from a fixed-seed xorshift, so every run is the same
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	import lp_seq_pkg::*;

	logic clk;
	logic rst;
	logic ce;
	regReq_t regReq;
	logic [31:0] rdData;
	logic enterReq;
	logic [1:0] modeReq;
	logic irqPending;
	wakeLines_t wakeLines;
	logic wakeUpPin;
	logic externalResetPin_n;
	logic watchdogReset;
	powerCtrl_t pwr;
	logic sysReset;
	logic irq;
	int fails;
	int checksDone;
	int cycles;
	int n;
	logic [31:0] seed;
	logic [31:0] rv;
	logic lp;

	low_power_mode_sequencer DUT (.clk(clk), .rst(rst), .ce(ce), .regReq(regReq),
		.rdData(rdData), .enterReq(enterReq), .modeReq(modeReq), .irqPending(irqPending),
		.wakeLines(wakeLines), .wakeUpPin(wakeUpPin), .externalResetPin_n(externalResetPin_n),
		.watchdogReset(watchdogReset), .pwr(pwr), .sysReset(sysReset), .irq(irq));

	core_wake_model core (.clk(clk), .enterReq(enterReq), .modeReq(modeReq),
		.wakeLines(wakeLines), .wakeUpPin(wakeUpPin), .watchdogReset(watchdogReset),
		.externalResetPin_n(externalResetPin_n));

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	function automatic logic [31:0] xorshift();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// status word: one-hot state in 12:8, standby flag in bit 0
	function automatic logic [31:0] status_word(input seqState_t s, input logic f);
		return {19'h0, s, 7'h0, f};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp) begin
			fails++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		regReq <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		regReq.wrEn <= 1'b0;
		// step off the edge so callers see what the write just updated
		#1;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		regReq <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk);
		regReq.rdEn <= 1'b0;
		#1;
		check(rdData, exp);
	endtask

	// bounded wait for running with the core clocked and no reset issued
	task automatic wait_run(input int lim);
		int k;
		k = 0;
		while (!(pwr.cpuClkEn === 1'b1 && sysReset === 1'b0) && k < lim) begin
			@(posedge clk);
			#1;
			k++;
		end
		check(32'(k < lim), 32'h1);
	endtask

	task automatic complete_run();
		$display("checks %0d fails %0d", checksDone, fails);
		if (fails == 0 && checksDone > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// a hang costs a mismatch and ends the run
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			fails++;
			complete_run();
		end
	end

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	initial begin
		seed = 32'hE743;
		fails = 0;
		checksDone = 0;
		cycles = 0;
		rst = 1'b1;
		ce = 1'b1;
		regReq = '0;
		irqPending = 1'b0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		check(32'(pwr), 32'(PWR_RUN));
		// a request seen only while ce is low must not be taken
		@(posedge clk);
		ce <= 1'b0;
		core.request(MODE_SLEEP);
		#1;
		check(32'(pwr.cpuClkEn), 32'h1);
		ce <= 1'b1;
		rdchk(OFF_CTRL, 32'h0);
		rdchk(OFF_STATUS, status_word(ST_RUN, 1'b0));
		rdchk(OFF_IRQ_STATUS, 32'h0);
		rdchk(OFF_IRQ_MASK, 32'h0);
		rdchk(8'h10, 32'h0);
		// the unused mode code must leave the block running
		core.request(2'h3);
		rdchk(OFF_STATUS, status_word(ST_RUN, 1'b0));
		// sleep: only the core clock stops, an interrupt resumes it
		core.request(MODE_SLEEP);
		#1;
		check(32'({pwr.cpuClkEn, pwr.periphClkEn, pwr.regMode}), 32'h4);
		rdchk(OFF_STATUS, status_word(ST_SLEEP, 1'b0));
		rv = xorshift();
		repeat (rv[1:0] + 1) @(posedge clk);
		irqPending <= 1'b1;
		wait_run(6);
		irqPending <= 1'b0;
		check(32'(irq), 32'h0);
		wr(OFF_IRQ_MASK, 32'h7);
		check(32'(irq), 32'h1);
		rdchk(OFF_IRQ_STATUS, 32'h1);
		check(32'(irq), 32'h0);
		// stop: woken by an event line, the watchdog, then the reset pin
		for (int i = 0; i < 3; i++) begin
			rv = xorshift();
			// a fresh random bit per pass, xored with the pass parity, picks the regulator choice
			lp = rv[0] ^ i[0];
			wr(OFF_CTRL, (rv & 32'hFFFFFFF0) | 32'h2 | 32'(lp));
			rdchk(OFF_CTRL, 32'h2 | 32'(lp));
			check(32'(pwr.sysClkIntOsc), 32'h0);
			core.request(MODE_STOP);
			#1;
			check(32'(pwr.regMode), lp ? 32'(REG_LOW_POWER) : 32'(REG_ON));
			check(32'({pwr.flashLowPower, pwr.pllAllow, pwr.intOscAllow, pwr.extOscAllow}),
				32'h8);
			rdchk(OFF_STATUS, status_word(ST_STOP, 1'b0));
			fork
				core.pulse(i == 0 ? int'(rv[12:8] % 20) : 20 + i);
				wait_run(60);
			join
			check(32'(pwr.sysClkIntOsc), 32'h1);
			if (i == 0) begin
				rdchk(OFF_CTRL, 32'(lp));
				rdchk(OFF_IRQ_STATUS, 32'h2);
			end
		end
		// standby: wake pin gives a counted system reset and sets the flag
		rv = xorshift();
		wr(OFF_CTRL, 32'(rv[0]) << CTRL_SRAM_RET_BIT);
		core.request(MODE_STANDBY);
		#1;
		check(32'(pwr.regMode), 32'(REG_OFF));
		check(32'({pwr.wakeCircuitOnly, pwr.flashPowerOff}), 32'h3);
		check(32'(pwr.sramRetain), 32'(rv[0]));
		n = 0;
		fork
			core.pulse(20);
			begin
				while (sysReset !== 1'b1 && n < 10) begin
					@(posedge clk);
					#1;
					n++;
				end
				check(32'(n < 10), 32'h1);
				n = 0;
				while (sysReset === 1'b1 && n < 40) begin
					@(posedge clk);
					#1;
					n++;
				end
			end
		join
		check(32'(n), 32'(WAKE_RST_CYCLES));
		wait_run(4);
		check(32'(pwr), 32'(PWR_RUN));
		rdchk(OFF_STATUS, status_word(ST_RUN, 1'b1));
		rdchk(OFF_IRQ_STATUS, 32'h4);
		wr(OFF_CTRL, 32'h0);
		rdchk(OFF_STATUS, status_word(ST_RUN, 1'b1));
		// software acknowledges the flag with the clear bit
		wr(OFF_CTRL, 32'h1 << CTRL_CLEAR_FLAG_BIT);
		rdchk(OFF_STATUS, status_word(ST_RUN, 1'b0));
		// standby again with the other retention choice; the voltage detector must
		// not wake it, an I/O event line must
		wr(OFF_CTRL, 32'(!rv[0]) << CTRL_SRAM_RET_BIT);
		core.request(MODE_STANDBY);
		#1;
		check(32'(pwr.sramRetain), 32'(!rv[0]));
		rv = xorshift();
		core.pulse(3);
		rdchk(OFF_STATUS, status_word(ST_STANDBY, 1'b0));
		fork
			core.pulse(4 + int'(rv[7:4]));
			wait_run(60);
		join
		rdchk(OFF_STATUS, status_word(ST_RUN, 1'b1));
		complete_run();
	end
endmodule
